// >>> rtl/rtc_prescaled_tick_alarm.sv
// Chosen here: the address map and strobed register access.
`timescale 1ns/10ps
// Overview of operation
// [RULE1] timer runs from main or low-frequency oscillator, apart from general timers
// [RULE2] timer keeps counting in idle or power-down when enabled
// [RULE3] cyclic interrupt every tick and every n ticks, routed to port 2 inputs
// [RULE4] combined long-term timer is 58 bits wide
// [RULE5] wake bit set: chip leaves power-down after programmed delay
// [RULE6] 20-bit divider clocked from fixed 1/64 predivided clock
// [RULE7] divider reloads from period reload register at each tick
// [RULE8] tick interrupt request may be issued once per tick
// [RULE9] 32-bit time counter increments per tick; software may load it
// [RULE10] time counter compared with loadable alarm; equal raises alarm request
// [RULE11] requests selectable as external interrupt sources; can wake power-down
// [RULE12] oscillator-off bit stops timer oscillator on power-down entry
// [RULE13] timer disabled: both oscillators off in power-down
// [RULE14] low-frequency oscillation seen at reset selects it as timer clock
// [RULE15] low-frequency source selected: main oscillator off in power-down
// [RULE16] no low-frequency oscillation at reset selects main oscillator
// [RULE17] main selected and timer enabled: main oscillator kept in power-down
// [RULE18] registers reached only over the peripheral register port
// [RULE19] tick and alarm requests separately enabled, pending until cleared
// [RULE20] time counter wraps to zero; alarm compared at every increment
module rtc_prescaled_tick_alarm
  import rtc_pkg::*;
(
  // clock and reset
  input  wire logic              clock,
  input  wire logic              sys_rst,
  // register port
  input  wire rtc_pkg::rtc_bus_req_t busReq,
  output logic [31:0]            busRdata,
  // system state
  input  wire rtc_pkg::rtc_sys_t sysState,
  // power control and interrupt lines
  output rtc_pkg::rtc_pwr_t      pwrCtrl,
  output logic                   tickIrqRequest,
  output logic                   alarmIrqRequest,
  output logic [1:0]             extIrqLine
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [RTC_CTRL_W-1:0] ctrl_r;
  logic [19:0]           tickPeriodReload_r;
  logic [19:0]           divider_r;
  logic [5:0]            prediv_r;
  logic [31:0]           time_r;
  logic [RTC_HIGH_W-1:0] high_r;
  logic [31:0]           alarm_r;
  logic [31:0]           nTick_r;
  logic [31:0]           nCount_r;
  logic [2:0]            pend_r;
  logic                  lfSel_r;
  logic                  rstSeen_r;
  logic [1:0]            extIrqSourceSelect_r;
  logic                  pdPrev_r;

  logic running;
  logic preTick;
  logic tick;
  logic nHit;
  logic alarmHit;
  logic wrCtrl;
  logic wrTime;
  logic wrStat;
  logic wake;
  logic [31:0] rdMux;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  function automatic logic isWr(input rtc_bus_req_t r, input logic [3:0] a);
    return r.wr && (r.addr == a);
  endfunction

  assign wrCtrl = isWr(busReq, RTC_ADDR_CTRL);
  assign wrTime = isWr(busReq, RTC_ADDR_TIME);
  assign wrStat = isWr(busReq, RTC_ADDR_STATUS);

  // timer keeps running in idle/power-down only when allowed
  assign running = ctrl_r[RTC_CTRL_RUN] &&
                   (!(sysState.powerDown || sysState.idle)
                    || ctrl_r[RTC_CTRL_RUNPD]);                  // [RULE2]
  assign preTick  = running && (prediv_r == RTC_PREDIV_MAX);     // [RULE6]
  assign tick     = preTick && (divider_r == 20'h0_0000);
  assign nHit     = tick && (nCount_r == 32'h0000_0000);
  assign alarmHit = tick && ((time_r + 32'h1) == alarm_r);       // [RULE10] [RULE20]

  // ---------------------------------------------------------------
  // clock source choice at reset release
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rstSeen_r <= 1'b0;
      lfSel_r   <= 1'b0;
    end else if (!rstSeen_r) begin
      rstSeen_r <= 1'b1;
      lfSel_r   <= sysState.lfPresent;                           // [RULE14] [RULE16] [RULE1]
    end
  end

  // ---------------------------------------------------------------
  // control and configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ctrl_r               <= RTC_CTRL_RST;
      tickPeriodReload_r   <= RTC_RELOAD_RST;
      alarm_r              <= 32'hffff_ffff;
      nTick_r              <= 32'h0000_0000;
      extIrqSourceSelect_r <= RTC_EXTSEL_RST;
    end else if (busReq.wr) begin                                // [RULE18]
      unique case (busReq.addr)
        RTC_ADDR_CTRL:   ctrl_r             <= busReq.wdata[RTC_CTRL_W-1:0];
        RTC_ADDR_RELOAD: tickPeriodReload_r <= busReq.wdata[19:0];
        RTC_ADDR_ALARM:  alarm_r            <= busReq.wdata;     // [RULE10]
        RTC_ADDR_NTICK:  nTick_r            <= busReq.wdata;
        RTC_ADDR_EXTSEL: extIrqSourceSelect_r <= busReq.wdata[1:0];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // prescaler: 1/64 predivider and 20-bit reloading divider
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      prediv_r <= 6'h00;
    end else if (running) begin
      prediv_r <= prediv_r + 6'h01;                              // [RULE6]
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      divider_r <= RTC_RELOAD_RST;
    end else if (tick) begin
      divider_r <= tickPeriodReload_r;                           // [RULE7]
    end else if (preTick) begin
      divider_r <= divider_r - 20'h0_0001;
    end
  end

  // ---------------------------------------------------------------
  // time counter, 26-bit extension to 58 bits, n-tick counter
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      time_r <= 32'h0000_0000;
      high_r <= '0;
    end else if (wrTime) begin
      time_r <= busReq.wdata;                                    // [RULE9]
    end else if (tick) begin
      time_r <= time_r + 32'h1;                                  // [RULE9] [RULE20]
      if (time_r == 32'hffff_ffff) begin
        high_r <= high_r + RTC_HIGH_W'(1);                       // [RULE4]
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      nCount_r <= 32'h0000_0000;
    end else if (isWr(busReq, RTC_ADDR_NTICK)) begin
      nCount_r <= busReq.wdata;
    end else if (nHit) begin
      nCount_r <= nTick_r;                                       // [RULE3]
    end else if (tick) begin
      nCount_r <= nCount_r - 32'h1;
    end
  end

  // ---------------------------------------------------------------
  // pending requests: set beats clear
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pend_r <= 3'h0;
    end else begin
      pend_r[RTC_ST_TICK]  <= (tick && ctrl_r[RTC_CTRL_TICKEN]) ||
                              (pend_r[RTC_ST_TICK] &&
                               !(wrStat && busReq.wdata[RTC_ST_TICK]));   // [RULE8] [RULE19]
      pend_r[RTC_ST_ALARM] <= (alarmHit && ctrl_r[RTC_CTRL_ALARMEN]) ||
                              (pend_r[RTC_ST_ALARM] &&
                               !(wrStat && busReq.wdata[RTC_ST_ALARM])); // [RULE19]
      pend_r[RTC_ST_NTICK] <= (nHit && ctrl_r[RTC_CTRL_NTICKEN]) ||
                              (pend_r[RTC_ST_NTICK] &&
                               !(wrStat && busReq.wdata[RTC_ST_NTICK])); // [RULE3]
    end
  end

  // ---------------------------------------------------------------
  // interrupt lines and port 2 routing
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tickIrqRequest  <= 1'b0;
      alarmIrqRequest <= 1'b0;
      extIrqLine      <= 2'h0;
    end else begin
      tickIrqRequest  <= pend_r[RTC_ST_TICK] | pend_r[RTC_ST_NTICK];     // [RULE3]
      alarmIrqRequest <= pend_r[RTC_ST_ALARM];
      extIrqLine[0]   <= extIrqSourceSelect_r[0] &
                         (pend_r[RTC_ST_TICK] | pend_r[RTC_ST_NTICK]);   // [RULE11]
      extIrqLine[1]   <= extIrqSourceSelect_r[1] & pend_r[RTC_ST_ALARM]; // [RULE11]
    end
  end

  // ---------------------------------------------------------------
  // power control
  // ---------------------------------------------------------------
  assign wake = ctrl_r[RTC_CTRL_WAKEEN] && sysState.powerDown &&
                (|pend_r);                                       // [RULE5] [RULE11]

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pwrCtrl  <= '0;
      pdPrev_r <= 1'b0;
    end else begin
      pdPrev_r <= sysState.powerDown;
      pwrCtrl.wake <= wake;
      if (!sysState.powerDown) begin
        pwrCtrl.mainOscOff <= 1'b0;
        pwrCtrl.lfOscOff   <= 1'b0;
      end else if (!ctrl_r[RTC_CTRL_RUN]) begin
        pwrCtrl.mainOscOff <= 1'b1;                              // [RULE13]
        pwrCtrl.lfOscOff   <= 1'b1;                              // [RULE13]
      end else if (!pdPrev_r) begin
        // decided on entry to power-down
        pwrCtrl.mainOscOff <= lfSel_r ||
                              ctrl_r[RTC_CTRL_OSCOFF];           // [RULE15] [RULE17] [RULE12]
        pwrCtrl.lfOscOff   <= lfSel_r &&
                              ctrl_r[RTC_CTRL_OSCOFF];           // [RULE12]
      end
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  always_comb begin
    rdMux = 32'h0000_0000;
    unique case (busReq.addr)
      RTC_ADDR_CTRL:    rdMux = {25'h0, ctrl_r};
      RTC_ADDR_STATUS:  rdMux = {28'h0, lfSel_r, pend_r};
      RTC_ADDR_RELOAD:  rdMux = {12'h0, tickPeriodReload_r};
      RTC_ADDR_DIVIDER: rdMux = {12'h0, divider_r};
      RTC_ADDR_TIME:    rdMux = time_r;
      RTC_ADDR_ALARM:   rdMux = alarm_r;
      RTC_ADDR_NTICK:   rdMux = nTick_r;
      RTC_ADDR_HIGHCNT: rdMux = {6'h0, high_r};
      RTC_ADDR_EXTSEL:  rdMux = {30'h0, extIrqSourceSelect_r};
      default:          rdMux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      busRdata <= 32'h0000_0000;
    end else begin
      busRdata <= busReq.rd ? rdMux : 32'h0000_0000;            // [RULE18]
    end
  end

endmodule

// >>> rtl/rtc_pkg.sv
package rtc_pkg;

  // ---------------------------------------------------------------
  // register map (word offsets on the plain register port)
  // ---------------------------------------------------------------
  localparam logic [3:0] RTC_ADDR_CTRL     = 4'h0;
  localparam logic [3:0] RTC_ADDR_STATUS   = 4'h1;
  localparam logic [3:0] RTC_ADDR_RELOAD   = 4'h2;
  localparam logic [3:0] RTC_ADDR_DIVIDER  = 4'h3;
  localparam logic [3:0] RTC_ADDR_TIME     = 4'h4;
  localparam logic [3:0] RTC_ADDR_ALARM    = 4'h5;
  localparam logic [3:0] RTC_ADDR_NTICK    = 4'h6;
  localparam logic [3:0] RTC_ADDR_HIGHCNT  = 4'h7;
  localparam logic [3:0] RTC_ADDR_EXTSEL   = 4'h8;

  // ---------------------------------------------------------------
  // control register fields
  // ---------------------------------------------------------------
  localparam int RTC_CTRL_RUN       = 0;
  localparam int RTC_CTRL_RUNPD     = 1;
  localparam int RTC_CTRL_OSCOFF    = 2;
  localparam int RTC_CTRL_TICKEN    = 3;
  localparam int RTC_CTRL_ALARMEN   = 4;
  localparam int RTC_CTRL_NTICKEN   = 5;
  localparam int RTC_CTRL_WAKEEN    = 6;
  localparam int RTC_CTRL_W         = 7;

  // status fields (write one to clear bits 0..2)
  localparam int RTC_ST_TICK        = 0;
  localparam int RTC_ST_ALARM       = 1;
  localparam int RTC_ST_NTICK       = 2;
  localparam int RTC_ST_LFSEL       = 3;

  // ---------------------------------------------------------------
  // reset values and counts
  // ---------------------------------------------------------------
  localparam logic [6:0]  RTC_CTRL_RST   = 7'h01;
  localparam logic [19:0] RTC_RELOAD_RST = 20'h0_0000;
  localparam logic [5:0]  RTC_PREDIV_MAX = 6'h3f;
  localparam int          RTC_PREDIV     = 64;
  localparam int          RTC_DIV_W      = 20;
  localparam int          RTC_TIME_W     = 32;
  localparam int          RTC_LONG_W     = 58;
  localparam int          RTC_HIGH_W     = RTC_LONG_W - RTC_TIME_W;
  localparam logic [1:0]  RTC_EXTSEL_RST = 2'h0;

  // ---------------------------------------------------------------
  // carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } rtc_bus_req_t;

  typedef struct packed {
    logic lfPresent;
    logic powerDown;
    logic idle;
  } rtc_sys_t;

  typedef struct packed {
    logic mainOscOff;
    logic lfOscOff;
    logic wake;
  } rtc_pwr_t;

endpackage

// >>> test/rtc_prescaled_tick_alarm_assertions.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// port checker
// ------------------------------------------------------------
module rtc_tick_checker
  import rtc_pkg::*;
(
  // clock and reset
  input wire logic                  clock,
  input wire logic                  sys_rst,
  // register port
  input wire rtc_pkg::rtc_bus_req_t busReq,
  input wire logic [31:0]           busRdata,
  // system state and power control
  input wire rtc_pkg::rtc_sys_t     sysState,
  input wire rtc_pkg::rtc_pwr_t     pwrCtrl,
  // requests
  input wire logic                  tickIrqRequest,
  input wire logic                  alarmIrqRequest,
  input wire logic [1:0]            extIrqLine
);
  logic [6:0] ctrl_r;
  logic [1:0] sel_r;
  logic       lfSel_r;
  logic       lfWait_r;

  // shadow of control and select registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ctrl_r <= RTC_CTRL_RST;
      sel_r  <= RTC_EXTSEL_RST;
    end else if (busReq.wr && busReq.addr == RTC_ADDR_CTRL) begin
      ctrl_r <= busReq.wdata[6:0];
    end else if (busReq.wr && busReq.addr == RTC_ADDR_EXTSEL) begin
      sel_r <= busReq.wdata[1:0];
    end
  end

  // clock source latched at the first edge after reset
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      lfWait_r <= 1'b1;
      lfSel_r  <= 1'b0;
    end else if (lfWait_r) begin
      lfWait_r <= 1'b0;
      lfSel_r  <= sysState.lfPresent;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence sPdOff;
    !sysState.powerDown ##1 (sysState.powerDown && !ctrl_r[RTC_CTRL_RUN]) [*2];
  endsequence
  sequence sPdMain;
    !sysState.powerDown ##1 (sysState.powerDown && ctrl_r[RTC_CTRL_RUN]
      && !ctrl_r[RTC_CTRL_OSCOFF] && !lfSel_r) [*2];
  endsequence

  a_rdata_idle: assert property (!$past(busReq.rd) |-> busRdata == 32'h0)
    else $error("read data present without a read");
  a_unmapped_zero: assert property ($past(busReq.rd) && ($past(busReq.addr) > RTC_ADDR_EXTSEL)
    |-> busRdata == 32'h0)
    else $error("unmapped read returned data");
  a_osc_awake: assert property (!$past(sysState.powerDown)
    |-> !pwrCtrl.mainOscOff && !pwrCtrl.lfOscOff)
    else $error("oscillator off outside power-down");
  a_lf_under_main: assert property (pwrCtrl.lfOscOff |-> pwrCtrl.mainOscOff)
    else $error("low-frequency oscillator off while main kept");
  a_pd_both_off: assert property (sPdOff |=> pwrCtrl.mainOscOff && pwrCtrl.lfOscOff)
    else $error("stopped timer left an oscillator on");
  a_pd_main_kept: assert property (sPdMain |=> !pwrCtrl.mainOscOff)
    else $error("main oscillator stopped while it clocks the timer");
  a_wake_cause: assert property (pwrCtrl.wake
    |-> $past(sysState.powerDown) && $past(ctrl_r[RTC_CTRL_WAKEEN]))
    else $error("wake without power-down or enable");
  a_ext_gated: assert property (!sel_r[0] && !$past(sel_r[0]) |-> !extIrqLine[0])
    else $error("tick routed while not selected");
endmodule

bind rtc_prescaled_tick_alarm rtc_tick_checker chk (
  .clock(clock), .sys_rst(sys_rst), .busReq(busReq), .busRdata(busRdata),
  .sysState(sysState), .pwrCtrl(pwrCtrl), .tickIrqRequest(tickIrqRequest),
  .alarmIrqRequest(alarmIrqRequest), .extIrqLine(extIrqLine));

// >>> test/rtc_prescaled_tick_alarm_tb_top.sv
`timescale 1ns/10ps
module rtc_prescaled_tick_alarm_tb_top;
  import rtc_pkg::*;
  logic         clock = 1'b0;
  logic         sys_rst = 1'b1;
  rtc_bus_req_t busReq = '0;
  logic [31:0]  busRdata;
  rtc_sys_t     sysState = '0;
  rtc_pwr_t     pwrCtrl;
  logic         tickIrqRequest;
  logic         alarmIrqRequest;
  logic [1:0]   extIrqLine;
  int           bad_count = 0;
  int           checks_done = 0;
  int           cyc = 0;
  logic [31:0]  rdv;

  always #12.5 clock = ~clock;

  rtc_prescaled_tick_alarm uut (.clock(clock), .sys_rst(sys_rst), .busReq(busReq),
    .busRdata(busRdata), .sysState(sysState), .pwrCtrl(pwrCtrl),
    .tickIrqRequest(tickIrqRequest), .alarmIrqRequest(alarmIrqRequest),
    .extIrqLine(extIrqLine));

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    busReq.addr  <= a;
    busReq.wdata <= d;
    busReq.wr    <= 1'b1;
    @(posedge clock);
    busReq.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock);
    busReq.addr <= a;
    busReq.rd   <= 1'b1;
    @(posedge clock);
    busReq.rd <= 1'b0;
    #1 d = busRdata;
  endtask
  // waits up to 1000 cycles for tick (0), alarm (1) or wake (2)
  task automatic waitSig(input int which, output int at);
    logic s;
    for (int n = 0; n < 1000; n++) begin
      @(posedge clock);
      #1;
      s = (which == 0) ? tickIrqRequest : (which == 1) ? alarmIrqRequest : pwrCtrl.wake;
      if (s === 1'b1) break;
    end
    at = cyc;
  endtask
  task automatic doReset(input logic lf);
    @(posedge clock);
    sys_rst <= 1'b1;
    sysState.lfPresent <= lf;
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
  endtask
  // enter power-down with a control word, compare oscillator controls, leave
  task automatic pdCase(input logic [31:0] c, input logic [1:0] e);
    wr(RTC_ADDR_CTRL, c);
    sysState.powerDown <= 1'b1;
    repeat (3) @(posedge clock);
    #1 chk({30'h0, pwrCtrl.mainOscOff, pwrCtrl.lfOscOff}, {30'h0, e}, "osc");
    @(posedge clock);
    sysState.powerDown <= 1'b0;
    repeat (2) @(posedge clock);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    rd(RTC_ADDR_CTRL, rdv);
    chk(rdv, 32'h1, "ctrl reset");
    rd(RTC_ADDR_RELOAD, rdv);
    chk(rdv, 32'h0, "reload reset");
    rd(RTC_ADDR_ALARM, rdv);
    chk(rdv, 32'hffff_ffff, "alarm reset");
    rd(RTC_ADDR_STATUS, rdv);
    chk(rdv & 32'h8, 32'h0, "main source");
    rd(4'hc, rdv);
    chk(rdv, 32'h0, "unmapped read");
    $display("test reset done");
  endtask
  task automatic t_tick();
    int r2;
    int r3;
    logic [31:0] t2;
    wr(RTC_ADDR_RELOAD, 32'h1);
    wr(RTC_ADDR_STATUS, 32'h7);
    wr(RTC_ADDR_CTRL, 32'h09);
    waitSig(0, r2);
    wr(RTC_ADDR_STATUS, 32'h7);
    repeat (2) @(posedge clock);
    waitSig(0, r2);
    rd(RTC_ADDR_TIME, t2);
    wr(RTC_ADDR_STATUS, 32'h7);
    repeat (2) @(posedge clock);
    waitSig(0, r3);
    rd(RTC_ADDR_TIME, rdv);
    chk(r3 - r2, 32'd128, "tick period");
    chk(rdv, t2 + 32'h1, "time step");
    wr(RTC_ADDR_NTICK, 32'h1);
    wr(RTC_ADDR_STATUS, 32'h7);
    wr(RTC_ADDR_CTRL, 32'h21);
    waitSig(0, r2);
    rd(RTC_ADDR_STATUS, rdv);
    chk(rdv & 32'h4, 32'h4, "n-tick pending");
    $display("test tick done");
  endtask
  task automatic t_alarm();
    int n;
    wr(RTC_ADDR_STATUS, 32'h7);
    wr(RTC_ADDR_ALARM, 32'h0);
    wr(RTC_ADDR_EXTSEL, 32'h2);
    wr(RTC_ADDR_CTRL, 32'h11);
    wr(RTC_ADDR_TIME, 32'hffff_ffff);
    waitSig(1, n);
    rd(RTC_ADDR_TIME, rdv);
    chk(rdv, 32'h0, "wrapped time");
    chk({31'h0, alarmIrqRequest}, 32'h1, "alarm held");
    chk({31'h0, tickIrqRequest}, 32'h0, "tick masked");
    chk({30'h0, extIrqLine}, 32'h2, "routing");
    wr(RTC_ADDR_STATUS, 32'h2);
    repeat (3) @(posedge clock);
    #1 chk({31'h0, alarmIrqRequest}, 32'h0, "alarm cleared");
    $display("test alarm done");
  endtask
  task automatic t_power();
    int n;
    pdCase(32'h03, 2'b00);
    pdCase(32'h00, 2'b11);
    wr(RTC_ADDR_STATUS, 32'h7);
    wr(RTC_ADDR_CTRL, 32'h4b);
    sysState.powerDown <= 1'b1;
    waitSig(2, n);
    chk({31'h0, pwrCtrl.wake}, 32'h1, "wake");
    sysState.powerDown <= 1'b0;
    doReset(1'b1);
    rd(RTC_ADDR_STATUS, rdv);
    chk(rdv & 32'h8, 32'h8, "lf source");
    pdCase(32'h01, 2'b10);
    pdCase(32'h05, 2'b11);
    $display("test power done");
  endtask

  // ------------------------------------------------------------
  // run control
  // ------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      close_out();
    end
  end
  initial begin
    doReset(1'b0);
    t_reset();
    t_tick();
    t_alarm();
    t_power();
    close_out();
  end
endmodule
